// ---- rtl/intc_map.svh ----
// Register offsets, field positions, reset values and vector numbers of the interrupt controller
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, lower 16 bits)
// ----------------------------------------------------------------------
`define OFS_PRIO_A 16'hfec0
`define OFS_PRIO_B 16'hfec1
`define OFS_PRIO_C 16'hfec2
`define OFS_SENSE_HI 16'hff2c
`define OFS_SENSE_LO 16'hff2d
`define OFS_PIN_ENABLE 16'hff2e
`define OFS_PIN_FLAGS 16'hff2f
`define OFS_SYSCTL 16'hff39

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define RST_SYSCTL 8'h01
`define RST_ZERO 8'h00
`define SYSCTL_WR_MASK 8'hb9
`define SYSCTL_MODE_HI 5
`define SYSCTL_MODE_LO 4
`define SYSCTL_NMI_EDGE 3
`define MODE_ONE 2'h1

// ----------------------------------------------------------------------
// Sizes and vector numbers
// ----------------------------------------------------------------------
`define NUM_IRQ 8
`define NUM_PERIPH 11
`define NUM_SRC 19
`define SRC_W 5
`define VEC_W 7
`define VEC_NMI 7'h07
`define VEC_TRAP_BASE 7'h08
`define VEC_SRC_BASE 7'h10

`endif

// ---- rtl/intc_pkg.sv ----
// Types shared by the interrupt controller modules
package intc_pkg;

  typedef logic [7:0] reg8_t;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_FALL = 2'h1,
    SENSE_RISE = 2'h2,
    SENSE_BOTH = 2'h3
  } sense_t;

endpackage : intc_pkg

// ---- rtl/pin_event_if.sv ----
// Carrier for the filtered level and edge pulses of one interrupt pin
`timescale 1ns/1ps
`default_nettype none

interface pin_event_if;
  logic lvl;
  logic fall;
  logic rise;

  modport src (output lvl, output fall, output rise);
  modport dst (input lvl, input fall, input rise);
endinterface : pin_event_if

`default_nettype wire

// ---- rtl/pin_sense.sv ----
// Pin synchroniser with agreement filter and edge detection
`timescale 1ns/1ps
`default_nettype none

module pin_sense (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  pin_event_if.src ev
);

  // ----------------------------------------------------------------------
  // Three-stage synchroniser; only stages two and three are compared
  // ----------------------------------------------------------------------
  logic meta_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;
  logic prev_ff;

  // Pins idle high, so reset to one to avoid a false edge on release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
    end else begin
      meta_ff <= pin;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      if (sync2_ff == sync3_ff) begin
        level_ff <= sync3_ff;
      end
      prev_ff <= level_ff;
    end
  end

  assign ev.lvl = level_ff;
  assign ev.fall = prev_ff & ~level_ff;
  assign ev.rise = ~prev_ff & level_ff;

endmodule : pin_sense

`default_nettype wire

// ---- rtl/interrupt_mode_priority_control.sv ----
// Interrupt controller: pin detection, masking by mode, priority, trap and transfer routing
`include "intc_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Mode field selects mode zero or one
// - Edge select bit picks nonmaskable falling/rising edge
// - Nonmaskable request always wins, never masked
// - Each pin configurable: fall, rise, both, low
// - Three 8-bit priority registers, read/write
// - Per-module levels give multiplexed interrupt control
// - Each source has its own vector number
// - Requests may start the transfer controller
// - System control resets to 01, standby too
// - Priority registers cleared by reset, standby
// - Flag register writes only clear, never set
// - Trap starts handling, vector from 2-bit number
// - Trap sets mask; user mask only in mode one
// - Priority bit clear is level 0, set level 1
// - Enable bits gate pins, cleared by reset
// - Sense codes: 00 low, 01 fall, 10 rise, 11 both
// - Flag clears by read-then-write-zero or handling

module interrupt_mode_priority_control
  import intc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic nmi_pin,
  input wire logic [`NUM_IRQ-1:0] ext_request_pins,
  input wire logic [`NUM_PERIPH-1:0] periph_req,
  input wire logic cpu_mask,
  input wire logic user_mask_bit,
  output logic int_req,
  output logic [`VEC_W-1:0] int_vector,
  input wire logic int_ack,
  input wire logic trap_instruction,
  input wire logic [1:0] trap_num,
  output logic trap_start,
  output logic [`VEC_W-1:0] trap_vector,
  output logic trap_set_mask,
  output logic trap_set_user_mask,
  input wire logic [`NUM_SRC-1:0] dtc_route,
  output logic dtc_req,
  output logic [`VEC_W-1:0] dtc_vector,
  input wire logic dtc_ack,
  input wire logic dtc_chain,
  output logic [1:0] ctrl_mode
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg8_t sysctl_ff;
  reg8_t prio_a_ff;
  reg8_t prio_b_ff;
  reg8_t prio_c_ff;
  reg8_t sense_hi_ff;
  reg8_t sense_lo_ff;
  reg8_t enable_ff;
  reg8_t flag_ff;
  reg8_t rd_seen_ff;
  reg8_t nxt_flag;
  reg8_t nxt_rd_seen;
  reg8_t reg_rdata_ff;
  logic nmi_pend_ff;
  logic [`NUM_SRC-1:0] cpu_pass_ff;

  logic wr_sysctl;
  logic wr_flags;
  logic rd_flags;
  logic mode_one;

  assign wr_sysctl = reg_wr && (reg_addr == `OFS_SYSCTL);
  assign wr_flags = reg_wr && (reg_addr == `OFS_PIN_FLAGS);
  assign rd_flags = reg_rd && (reg_addr == `OFS_PIN_FLAGS);
  // Prohibited encodings fall back to mode zero behaviour
  assign mode_one = ({sysctl_ff[`SYSCTL_MODE_HI], sysctl_ff[`SYSCTL_MODE_LO]} == `MODE_ONE);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Hardware standby reinitialises; software standby simply keeps the clock off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sysctl_ff <= `RST_SYSCTL;
    end else if (hw_standby) begin
      sysctl_ff <= `RST_SYSCTL;
    end else if (wr_sysctl) begin
      sysctl_ff <= (reg_wdata & `SYSCTL_WR_MASK) | (sysctl_ff & ~`SYSCTL_WR_MASK);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_a_ff <= `RST_ZERO;
      prio_b_ff <= `RST_ZERO;
      prio_c_ff <= `RST_ZERO;
    end else if (hw_standby) begin
      prio_a_ff <= `RST_ZERO;
      prio_b_ff <= `RST_ZERO;
      prio_c_ff <= `RST_ZERO;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_PRIO_A) begin
        prio_a_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_PRIO_B) begin
        prio_b_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_PRIO_C) begin
        prio_c_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_hi_ff <= `RST_ZERO;
      sense_lo_ff <= `RST_ZERO;
      enable_ff <= `RST_ZERO;
    end else if (hw_standby) begin
      sense_hi_ff <= `RST_ZERO;
      sense_lo_ff <= `RST_ZERO;
      enable_ff <= `RST_ZERO;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_SENSE_HI) begin
        sense_hi_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_SENSE_LO) begin
        sense_lo_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_PIN_ENABLE) begin
        enable_ff <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin detection
  // ----------------------------------------------------------------------
  pin_event_if nmi_ev ();
  pin_event_if irq_ev [`NUM_IRQ] ();
  logic [15:0] sense_all;
  reg8_t pin_set;
  reg8_t pin_lvl;
  logic nmi_event;

  assign sense_all = {sense_hi_ff, sense_lo_ff};

  pin_sense u_nmi_sense (
    .core_clk (core_clk),
    .rst_n (rst_n),
    .pin (nmi_pin),
    .ev (nmi_ev.src)
  );

  assign nmi_event = sysctl_ff[`SYSCTL_NMI_EDGE] ? nmi_ev.rise : nmi_ev.fall;

  for (genvar n = 0; n < `NUM_IRQ; n++) begin : g_pin
    sense_t sel;

    pin_sense u_sense (
      .core_clk (core_clk),
      .rst_n (rst_n),
      .pin (ext_request_pins[n]),
      .ev (irq_ev[n].src)
    );

    assign sel = sense_t'(sense_all[2*n +: 2]);
    assign pin_lvl[n] = irq_ev[n].lvl;

    always_comb begin
      unique case (sel)
        SENSE_LOW: pin_set[n] = ~irq_ev[n].lvl;
        SENSE_FALL: pin_set[n] = irq_ev[n].fall;
        SENSE_RISE: pin_set[n] = irq_ev[n].rise;
        SENSE_BOTH: pin_set[n] = irq_ev[n].fall | irq_ev[n].rise;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Selection of the source shown to the CPU and to the transfer controller
  // ----------------------------------------------------------------------
  logic [`NUM_SRC-1:0] src_pend;
  logic [`NUM_SRC-1:0] src_level;
  logic [`NUM_SRC-1:0] to_dtc;
  logic [`NUM_SRC-1:0] cpu_cand;
  logic [`NUM_SRC-1:0] cpu_cand_hi;
  logic [`NUM_SRC-1:0] dtc_cand;
  logic [`SRC_W-1:0] cpu_pick;
  logic [`SRC_W-1:0] dtc_pick;
  logic int_req_ff;
  logic int_nmi_ff;
  logic [`SRC_W-1:0] int_src_ff;
  logic [`VEC_W-1:0] int_vector_ff;
  logic dtc_req_ff;
  logic [`SRC_W-1:0] dtc_src_ff;
  logic [`VEC_W-1:0] dtc_vector_ff;

  function automatic logic [`SRC_W-1:0] lowest_idx(input logic [`NUM_SRC-1:0] v);
    logic [`SRC_W-1:0] idx;
    idx = '0;
    for (int s = `NUM_SRC - 1; s >= 0; s--) begin
      if (v[s]) begin
        idx = `SRC_W'(s);
      end
    end
    return idx;
  endfunction : lowest_idx

  // Several sources of one module share a single level bit
  assign src_level = {
    prio_c_ff[2], prio_c_ff[3], prio_c_ff[4], prio_c_ff[6], prio_c_ff[7],
    prio_b_ff[3], prio_b_ff[4], prio_b_ff[5], prio_b_ff[6],
    prio_a_ff[1], prio_a_ff[2],
    prio_a_ff[3], prio_a_ff[3], prio_a_ff[4], prio_a_ff[4],
    prio_a_ff[5], prio_a_ff[5], prio_a_ff[6], prio_a_ff[7]
  };

  assign src_pend = {periph_req, flag_ff & enable_ff};
  assign to_dtc = dtc_route & ~cpu_pass_ff;

  always_comb begin
    for (int s = 0; s < `NUM_SRC; s++) begin
      if (!mode_one) begin
        cpu_cand[s] = src_pend[s] & ~to_dtc[s] & ~cpu_mask;
      end else begin
        cpu_cand[s] = src_pend[s] & ~to_dtc[s] &
                      (~cpu_mask | (~user_mask_bit & src_level[s]));
      end
    end
  end

  assign cpu_cand_hi = mode_one ? (cpu_cand & src_level) : '0;
  assign cpu_pick = lowest_idx((|cpu_cand_hi) ? cpu_cand_hi : cpu_cand);
  assign dtc_cand = src_pend & to_dtc;
  assign dtc_pick = lowest_idx(dtc_cand);

  // A one-cycle gap after each acknowledge lets the clear settle before reselection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_req_ff <= 1'b0;
      int_nmi_ff <= 1'b0;
      int_src_ff <= '0;
      int_vector_ff <= '0;
    end else if (int_ack || hw_standby) begin
      int_req_ff <= 1'b0;
      int_nmi_ff <= 1'b0;
    end else if (nmi_pend_ff) begin
      int_req_ff <= 1'b1;
      int_nmi_ff <= 1'b1;
      int_vector_ff <= `VEC_NMI;
    end else begin
      int_req_ff <= |cpu_cand;
      int_nmi_ff <= 1'b0;
      int_src_ff <= cpu_pick;
      int_vector_ff <= `VEC_SRC_BASE + `VEC_W'(cpu_pick);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dtc_req_ff <= 1'b0;
      dtc_src_ff <= '0;
      dtc_vector_ff <= '0;
    end else if (dtc_ack || hw_standby) begin
      dtc_req_ff <= 1'b0;
    end else begin
      dtc_req_ff <= |dtc_cand;
      dtc_src_ff <= dtc_pick;
      dtc_vector_ff <= `VEC_SRC_BASE + `VEC_W'(dtc_pick);
    end
  end

  // Sources the transfer controller handed on stay with the CPU until it takes them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_pass_ff <= '0;
    end else if (hw_standby) begin
      cpu_pass_ff <= '0;
    end else begin
      for (int s = 0; s < `NUM_SRC; s++) begin
        if (dtc_ack && dtc_chain && (dtc_src_ff == `SRC_W'(s))) begin
          cpu_pass_ff[s] <= 1'b1;
        end else if (int_ack && !int_nmi_ff && (int_src_ff == `SRC_W'(s))) begin
          cpu_pass_ff[s] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Nonmaskable pending bit and pin request flags
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_ff <= 1'b0;
    end else if (hw_standby) begin
      nmi_pend_ff <= 1'b0;
    end else if (nmi_event) begin
      nmi_pend_ff <= 1'b1;
    end else if (int_ack && int_nmi_ff) begin
      nmi_pend_ff <= 1'b0;
    end
  end

  always_comb begin
    for (int n = 0; n < `NUM_IRQ; n++) begin
      logic sw_clr;
      logic hs_clr;
      logic dt_clr;
      sw_clr = wr_flags && !reg_wdata[n] && rd_seen_ff[n];
      hs_clr = int_ack && !int_nmi_ff && (int_src_ff == `SRC_W'(n)) &&
               ((sense_all[2*n +: 2] != SENSE_LOW) || pin_lvl[n]);
      dt_clr = dtc_ack && !dtc_chain && (dtc_src_ff == `SRC_W'(n));
      // A new detection in the clearing cycle is kept
      nxt_flag[n] = pin_set[n] | (flag_ff[n] & ~(sw_clr | hs_clr | dt_clr));
      nxt_rd_seen[n] = nxt_flag[n] & (rd_seen_ff[n] | (rd_flags & flag_ff[n]));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= `RST_ZERO;
      rd_seen_ff <= `RST_ZERO;
    end else if (hw_standby) begin
      flag_ff <= `RST_ZERO;
      rd_seen_ff <= `RST_ZERO;
    end else begin
      flag_ff <= nxt_flag;
      rd_seen_ff <= nxt_rd_seen;
    end
  end

  // ----------------------------------------------------------------------
  // Trap handling
  // ----------------------------------------------------------------------
  logic trap_start_ff;
  logic trap_set_mask_ff;
  logic trap_set_user_mask_ff;
  logic [`VEC_W-1:0] trap_vector_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_start_ff <= 1'b0;
      trap_set_mask_ff <= 1'b0;
      trap_set_user_mask_ff <= 1'b0;
      trap_vector_ff <= '0;
    end else begin
      trap_start_ff <= trap_instruction;
      trap_set_mask_ff <= trap_instruction;
      trap_set_user_mask_ff <= trap_instruction && mode_one;
      if (trap_instruction) begin
        trap_vector_ff <= `VEC_TRAP_BASE + `VEC_W'(trap_num);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= `RST_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_PRIO_A: reg_rdata_ff <= prio_a_ff;
        `OFS_PRIO_B: reg_rdata_ff <= prio_b_ff;
        `OFS_PRIO_C: reg_rdata_ff <= prio_c_ff;
        `OFS_SENSE_HI: reg_rdata_ff <= sense_hi_ff;
        `OFS_SENSE_LO: reg_rdata_ff <= sense_lo_ff;
        `OFS_PIN_ENABLE: reg_rdata_ff <= enable_ff;
        `OFS_PIN_FLAGS: reg_rdata_ff <= flag_ff;
        `OFS_SYSCTL: reg_rdata_ff <= sysctl_ff;
        default: reg_rdata_ff <= `RST_ZERO;
      endcase
    end else begin
      reg_rdata_ff <= `RST_ZERO;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign int_req = int_req_ff;
  assign int_vector = int_vector_ff;
  assign dtc_req = dtc_req_ff;
  assign dtc_vector = dtc_vector_ff;
  assign trap_start = trap_start_ff;
  assign trap_vector = trap_vector_ff;
  assign trap_set_mask = trap_set_mask_ff;
  assign trap_set_user_mask = trap_set_user_mask_ff;
  assign ctrl_mode = {sysctl_ff[`SYSCTL_MODE_HI], sysctl_ff[`SYSCTL_MODE_LO]};

endmodule : interrupt_mode_priority_control

`default_nettype wire

// ---- verification/interrupt_mode_priority_control_properties.sv ----
// Port-level assertions for the interrupt controller
`include "intc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module intc_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_mask,
  input wire logic user_mask_bit,
  input wire logic int_req,
  input wire logic [`VEC_W-1:0] int_vector,
  input wire logic int_ack,
  input wire logic trap_instruction,
  input wire logic [1:0] trap_num,
  input wire logic trap_start,
  input wire logic [`VEC_W-1:0] trap_vector,
  input wire logic trap_set_mask,
  input wire logic trap_set_user_mask,
  input wire logic dtc_req,
  input wire logic dtc_ack,
  input wire logic [1:0] ctrl_mode
);
  logic blk;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Two cycles of masking cover a registered copy of the mask inputs
  assign blk = (ctrl_mode == 2'h0 && cpu_mask) ||
               (ctrl_mode == `MODE_ONE && cpu_mask && user_mask_bit);
  sequence s_trap;
    trap_instruction ##1 trap_start;
  endsequence
  AST_TRAP_TAKEN: assert property (trap_instruction && !hw_standby |=> trap_start)
    else $error("trap not started");
  AST_TRAP_VEC: assert property (s_trap |->
    trap_set_mask && trap_vector == `VEC_TRAP_BASE + $past(trap_num))
    else $error("trap vector or mask wrong");
  AST_TRAP_UMASK: assert property (s_trap |->
    trap_set_user_mask == ($past(ctrl_mode) == `MODE_ONE))
    else $error("user mask set wrong");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_STBY: assert property (hw_standby |=> ctrl_mode == 2'h0 && !int_req && !dtc_req)
    else $error("standby did not reinit");
  AST_ACK_DROP: assert property (int_ack |=> !int_req)
    else $error("request held after ack");
  AST_DTC_DROP: assert property (dtc_ack |=> !dtc_req)
    else $error("transfer request held after ack");
  AST_MASKED: assert property (int_req && $past(blk) && $past(blk, 2) |->
    int_vector == `VEC_NMI)
    else $error("masked request shown");
  AST_VEC_OK: assert property (int_req |-> int_vector == `VEC_NMI ||
    (int_vector >= `VEC_SRC_BASE && int_vector < `VEC_SRC_BASE + `NUM_SRC))
    else $error("vector out of range");
endmodule : intc_props

bind interrupt_mode_priority_control intc_props props_u (
  .core_clk(core_clk), .rst_n(rst_n), .hw_standby(hw_standby), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cpu_mask(cpu_mask), .user_mask_bit(user_mask_bit),
  .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack),
  .trap_instruction(trap_instruction), .trap_num(trap_num), .trap_start(trap_start),
  .trap_vector(trap_vector), .trap_set_mask(trap_set_mask),
  .trap_set_user_mask(trap_set_user_mask), .dtc_req(dtc_req), .dtc_ack(dtc_ack),
  .ctrl_mode(ctrl_mode));

`default_nettype wire

// ---- verification/intc_cpu_model.sv ----
// CPU side model that takes shown vectors after a chosen latency
`timescale 1ns/1ps
`default_nettype none

module intc_cpu_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic int_req,
  input wire logic [6:0] int_vector,
  input wire logic ack_en,
  input wire logic [1:0] lat,
  output logic int_ack,
  output logic [6:0] last_vec,
  output logic [7:0] n_taken
);
  logic [1:0] wait_ff;
  // Model pushes nothing, so the even stack pointer stays with software
  // --------------------------------------------------------------------
  // Acknowledge only while a request is shown
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 2'h0;
      int_ack <= 1'b0;
    end else if (int_req && ack_en && !int_ack && wait_ff == lat) begin
      wait_ff <= 2'h0;
      int_ack <= 1'b1;
    end else begin
      wait_ff <= (int_req && ack_en && !int_ack) ? wait_ff + 2'h1 : 2'h0;
      int_ack <= 1'b0;
    end
  end
  // The vector is the one shown at the edge where the ack is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_vec <= 7'h00;
      n_taken <= 8'h00;
    end else if (int_ack) begin
      last_vec <= int_vector;
      n_taken <= n_taken + 8'h01;
    end
  end
endmodule : intc_cpu_model

`default_nettype wire

// ---- verification/interrupt_mode_priority_control_tb_top.sv ----
// Self-checking bench for the interrupt controller
`include "intc_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end

module interrupt_mode_priority_control_tb_top
  import intc_pkg::*;
;
  logic core_clk, rst_n, hw_standby, reg_wr, reg_rd, nmi_pin, cpu_mask, user_mask_bit;
  logic int_req, int_ack, trap_instruction, trap_start, trap_set_mask, trap_set_user_mask;
  logic dtc_req, dtc_ack, dtc_chain, ack_en;
  logic [15:0] reg_addr;
  reg8_t reg_wdata, reg_rdata;
  logic [7:0] ext_request_pins, n_taken, n0;
  logic [10:0] periph_req;
  logic [6:0] int_vector, trap_vector, dtc_vector, last_vec;
  logic [1:0] trap_num, ctrl_mode, lat;
  logic [18:0] dtc_route;
  int n_fail, total_checks;
  logic [15:0] ra [8] = '{`OFS_PRIO_A, `OFS_PRIO_B, `OFS_PRIO_C, `OFS_SENSE_HI,
    `OFS_SENSE_LO, `OFS_PIN_ENABLE, `OFS_PIN_FLAGS, `OFS_SYSCTL};

  interrupt_mode_priority_control dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .hw_standby(hw_standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nmi_pin(nmi_pin), .ext_request_pins(ext_request_pins), .periph_req(periph_req),
    .cpu_mask(cpu_mask), .user_mask_bit(user_mask_bit), .int_req(int_req),
    .int_vector(int_vector), .int_ack(int_ack), .trap_instruction(trap_instruction),
    .trap_num(trap_num), .trap_start(trap_start), .trap_vector(trap_vector),
    .trap_set_mask(trap_set_mask), .trap_set_user_mask(trap_set_user_mask),
    .dtc_route(dtc_route), .dtc_req(dtc_req), .dtc_vector(dtc_vector),
    .dtc_ack(dtc_ack), .dtc_chain(dtc_chain), .ctrl_mode(ctrl_mode));

  intc_cpu_model cpu_u (
    .core_clk(core_clk), .rst_n(rst_n), .int_req(int_req), .int_vector(int_vector),
    .ack_en(ack_en), .lat(lat), .int_ack(int_ack), .last_vec(last_vec),
    .n_taken(n_taken));

  always #10 core_clk = ~core_clk;

  // --------------------------------------------------------------------
  // Bus tasks and verdict
  // --------------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input reg8_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input reg8_t e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK(reg_rdata, e)
    @(posedge core_clk);
  endtask : rd

  task automatic waitn(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : waitn

  task automatic chk_req(input logic r, input logic [6:0] v);
    waitn(6);
    `CHK(int_req, r)
    if (r) `CHK(int_vector, v)
    @(posedge core_clk);
  endtask : chk_req

  task automatic print_verdict;
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    print_verdict();
  end

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {hw_standby, reg_wr, reg_rd, cpu_mask, user_mask_bit, trap_instruction} = '0;
    {dtc_ack, dtc_chain, ack_en, reg_addr, reg_wdata, trap_num, lat} = '0;
    {periph_req, dtc_route} = '0;
    nmi_pin = 1'b1;
    ext_request_pins = 8'hff;
    n_fail = 0;
    total_checks = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ra[i], i == 7 ? `RST_SYSCTL : `RST_ZERO);
    rd(16'hff30, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], 8'(8'h5a ^ i));
      rd(ra[i], 8'(8'h5a ^ i));
      wr(ra[i], 8'h00);
    end
    wr(`OFS_SYSCTL, 8'hdf);
    rd(`OFS_SYSCTL, 8'h99);
    wr(`OFS_SYSCTL, 8'h01);
    wr(`OFS_PIN_FLAGS, 8'hff);
    rd(`OFS_PIN_FLAGS, 8'h00);
    // Level request held off by the mask so the flag can be inspected
    cpu_mask <= 1'b1;
    wr(`OFS_PIN_ENABLE, 8'h01);
    ext_request_pins[0] <= 1'b0;
    waitn(10);
    rd(`OFS_PIN_FLAGS, 8'h01);
    @(posedge core_clk) ext_request_pins[0] <= 1'b1;
    wr(`OFS_PIN_FLAGS, 8'hff);
    rd(`OFS_PIN_FLAGS, 8'h01);
    wr(`OFS_PIN_FLAGS, 8'h00);
    rd(`OFS_PIN_FLAGS, 8'h00);
    cpu_mask <= 1'b0;
    ack_en <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      lat <= 2'(c);
      wr(`OFS_SENSE_LO, 8'(c << (2 * c)));
      wr(`OFS_PIN_ENABLE, 8'(1 << c));
      n0 = n_taken;
      ext_request_pins[c] <= 1'b0;
      waitn(12);
      @(posedge core_clk) ext_request_pins[c] <= 1'b1;
      waitn(12);
      `CHK(8'(n_taken - n0), 8'(c == 3 ? 2 : 1))
      `CHK(last_vec, 7'(`VEC_SRC_BASE + c))
      rd(`OFS_PIN_FLAGS, 8'h00);
    end
    ack_en <= 1'b0;
    wr(`OFS_PIN_ENABLE, 8'h00);
    wr(`OFS_SYSCTL, 8'h11);
    wr(`OFS_PRIO_A, 8'h02);
    cpu_mask <= 1'b1;
    periph_req <= 11'h003;
    chk_req(1'b1, 7'h19);
    cpu_mask <= 1'b0;
    chk_req(1'b1, 7'h19);
    wr(`OFS_PRIO_A, 8'h00);
    chk_req(1'b1, 7'h18);
    cpu_mask <= 1'b1;
    chk_req(1'b0, 7'h00);
    wr(`OFS_PRIO_A, 8'h02);
    user_mask_bit <= 1'b1;
    chk_req(1'b0, 7'h00);
    wr(`OFS_SYSCTL, 8'h01);
    cpu_mask <= 1'b0;
    chk_req(1'b1, 7'h18);
    cpu_mask <= 1'b1;
    chk_req(1'b0, 7'h00);
    // Nonmaskable edge while every maskable source is blocked
    ack_en <= 1'b1;
    n0 = n_taken;
    nmi_pin <= 1'b0;
    waitn(12);
    @(posedge core_clk) nmi_pin <= 1'b1;
    waitn(12);
    `CHK(8'(n_taken - n0), 8'h01)
    `CHK(last_vec, `VEC_NMI)
    wr(`OFS_SYSCTL, 8'h09);
    nmi_pin <= 1'b0;
    waitn(12);
    @(posedge core_clk) nmi_pin <= 1'b1;
    waitn(12);
    `CHK(8'(n_taken - n0), 8'h02)
    for (int m = 0; m < 2; m++) begin
      wr(`OFS_SYSCTL, m ? 8'h11 : 8'h01);
      for (int n = 0; n < 4; n++) begin
        @(posedge core_clk);
        trap_instruction <= 1'b1;
        trap_num <= 2'(n);
        @(posedge core_clk);
        trap_instruction <= 1'b0;
        @(negedge core_clk);
        `CHK({trap_start, trap_set_mask, trap_vector}, {2'b11, 7'(8 + n)})
        `CHK(trap_set_user_mask, 1'(m))
      end
    end
    @(posedge core_clk);
    periph_req <= 11'h004;
    dtc_route <= 19'h00400;
    waitn(6);
    `CHK({dtc_req, dtc_vector}, {1'b1, 7'h1a})
    @(posedge core_clk);
    dtc_ack <= 1'b1;
    dtc_chain <= 1'b1;
    cpu_mask <= 1'b0;
    @(posedge core_clk);
    dtc_ack <= 1'b0;
    @(negedge core_clk);
    `CHK(dtc_req, 1'b0)
    // Chained source goes to the CPU once, then back to the transfer controller
    waitn(12);
    `CHK({last_vec, dtc_req}, {7'h1a, 1'b1})
    wr(`OFS_PRIO_B, 8'h3c);
    wr(`OFS_SYSCTL, 8'h19);
    @(posedge core_clk);
    hw_standby <= 1'b1;
    @(posedge core_clk);
    hw_standby <= 1'b0;
    rd(`OFS_PRIO_B, 8'h00);
    rd(`OFS_SYSCTL, 8'h01);
    print_verdict();
  end
endmodule : interrupt_mode_priority_control_tb_top

`default_nettype wire
